// ==== rtp_pkg.sv ====
// Shared constants and types for the real-time pin 0 output selector
package rtp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [4:0] IDX_SYNC_BEGIN = 5'h06;
    localparam logic [4:0] IDX_SYNC_STOP = 5'h07;
    localparam logic [4:0] IDX_MODE_DELAY = 5'h11;
    localparam logic [4:0] IDX_OUTPUT_SEL = 5'h12;
    localparam logic [4:0] IDX_OUT_CTRL = 5'h13;
    localparam logic [4:0] IDX_VSTART_LO = 5'h15;
    localparam logic [4:0] IDX_VSTOP_LO = 5'h16;
    localparam logic [4:0] IDX_VERT_CTRL = 5'h17;
    localparam logic [4:0] IDX_STATUS = 5'h1F;
    // Field positions
    localparam int POS_INVERT = 3;
    localparam int POS_FINE_DELAY = 4;
    localparam int POS_LOCK_SPEED = 3;
    localparam int POS_VSTART_MSB = 0;
    localparam int POS_VSTOP_MSB = 1;
    localparam int POS_GATE_ADJUST = 2;
    // Values after reset
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [16:0] RST_PHASE = 17'h00000;
    // Qualifier rates, derived into a phase step per system clock
    localparam int CLK_KHZ = 100000;
    localparam int PIXEL_KHZ = 13500;
    localparam logic [16:0] PHASE_STEP = 17'(2 * PIXEL_KHZ);
    localparam logic [16:0] PHASE_WRAP = 17'(CLK_KHZ);
    // Sync width step is eight clocks, fine step two clocks
    localparam int SYNC_STEP_SHIFT = 3;
    localparam int FINE_STEP_CLKS = 2;
    localparam int FINE_MAX_CLKS = 6;
    // Source select codes
    typedef enum logic [3:0] {
        SEL_TRISTATE = 4'b0000,
        SEL_LOW = 4'b0001,
        SEL_PIXEL_QUAL = 4'b0010,
        SEL_HALF_QUAL = 4'b0011,
        SEL_HLOCK = 4'b0100,
        SEL_FULL_LOCK = 4'b0101,
        SEL_LOCK_COLOUR = 4'b0110,
        SEL_LINE_REF = 4'b1000,
        SEL_HSYNC = 4'b1001,
        SEL_GATED_REF = 4'b1010,
        SEL_VSYNC = 4'b1100,
        SEL_VERTICAL_WINDOW_GATE = 4'b1101,
        SEL_ADC_LSB = 4'b1110,
        SEL_FIELD = 4'b1111
    } rtp_sel_t;
endpackage

// ==== rtp_timing_if.sv ====
// Timing configuration and results between the selector and its generators
`timescale 1ns/1ps
interface rtp_timing_if;
    logic [10:0] pixelCount;
    logic [8:0] lineCount;
    logic [7:0] syncBeginPos;
    logic [7:0] syncStopPos;
    logic [1:0] horizFineDelay;
    logic [8:0] vertStartLine;
    logic [8:0] vertStopLine;
    logic vertGateAdjust;
    logic horizSyncPulse;
    logic verticalWindowGate;

    modport hsGen (
        input pixelCount,
        input syncBeginPos,
        input syncStopPos,
        input horizFineDelay,
        output horizSyncPulse
    );
    modport vgGen (
        input lineCount,
        input vertStartLine,
        input vertStopLine,
        input vertGateAdjust,
        output verticalWindowGate
    );
endinterface

// ==== rtp_hsync_gen.sv ====
// Horizontal sync pulse with coarse width and fine position delay
`timescale 1ns/1ps
module rtp_hsync_gen (
    input wire logic clk_sys,
    input wire logic resetn,
    rtp_timing_if.hsGen tim
);
    logic rawSync;
    logic [rtp_pkg::FINE_MAX_CLKS:0] delayQ;
    logic [2:0] tap;
    logic [7:0] coarsePos;

    // Coarse position counts in eight-clock steps
    assign coarsePos = tim.pixelCount[rtp_pkg::SYNC_STEP_SHIFT +: 8];
    assign rawSync = (coarsePos >= tim.syncBeginPos) &&
                     (coarsePos < tim.syncStopPos);
    assign delayQ[0] = rawSync;

    // Delay line; one tap per clock so every fine step is reachable
    genvar i;
    generate
        for (i = 1; i <= rtp_pkg::FINE_MAX_CLKS; i++) begin : gStage
            always_ff @(posedge clk_sys) begin
                if (!resetn) begin
                    delayQ[i] <= 1'b0;
                end else begin
                    delayQ[i] <= delayQ[i-1];
                end
            end
        end
    endgenerate

    assign tap = 3'({1'b0, tim.horizFineDelay} * 3'(rtp_pkg::FINE_STEP_CLKS));
    assign tim.horizSyncPulse = delayQ[tap];
endmodule

// ==== rtp_vertical_window_gate_gen.sv ====
// Vertical window gate between a start and a stop line
`timescale 1ns/1ps
module rtp_vertical_window_gate_gen (
    input wire logic clk_sys,
    input wire logic resetn,
    rtp_timing_if.vgGen tim
);
    logic gateQ;
    logic [8:0] effLine;

    // Adjust bit moves both gate edges one line later
    assign effLine = tim.vertGateAdjust ? 9'(tim.lineCount - 9'h001) :
                     tim.lineCount;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            gateQ <= 1'b0;
        end else if (effLine == tim.vertStartLine) begin
            gateQ <= 1'b1;
        end else if (effLine == tim.vertStopLine) begin
            gateQ <= 1'b0;
        end
    end
    assign tim.verticalWindowGate = gateQ;
endmodule

// ==== rtp_output_select.sv ====
// Real-time pin 0 source selector with APB register access
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module rtp_output_select (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [10:0] pixelCount,
    input wire logic [8:0] lineCount,
    input wire logic hLockStandard,
    input wire logic hLockFast,
    input wire logic vLock,
    input wire logic colourDetect,
    input wire logic activeLineRef,
    input wire logic verticalSyncOut,
    input wire logic adcLsb,
    input wire logic fieldParity,
    output logic realtimePin0Out,
    output logic realtimePin0OeN
);
    rtp_timing_if tim();

    logic [7:0] syncBeginQ;
    logic [7:0] syncStopQ;
    logic [7:0] modeDelayQ;
    logic [7:0] outputSelQ;
    logic [7:0] outCtrlQ;
    logic [7:0] vStartLoQ;
    logic [7:0] vStopLoQ;
    logic [7:0] vertCtrlQ;
    logic [31:0] prdataQ;
    logic [4:0] regIdx;
    logic wrEn;
    logic [16:0] phaseQ;
    logic pixelQualQ;
    logic halfQualQ;
    logic fieldIdentQ;
    logic pinQ;
    logic oeNQ;
    logic pinD;
    logic oeND;
    logic selRaw;
    logic horizontalLockFlag;
    logic realtimePin0Invert;
    rtp_pkg::rtp_sel_t srcSel;

    // Offset decode shared by write enable and error answer
    function automatic logic isMapped(input logic [4:0] idx);
        unique case (idx)
            rtp_pkg::IDX_SYNC_BEGIN, rtp_pkg::IDX_SYNC_STOP,
            rtp_pkg::IDX_MODE_DELAY, rtp_pkg::IDX_OUTPUT_SEL,
            rtp_pkg::IDX_OUT_CTRL, rtp_pkg::IDX_VSTART_LO,
            rtp_pkg::IDX_VSTOP_LO, rtp_pkg::IDX_VERT_CTRL,
            rtp_pkg::IDX_STATUS: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    // Word index; upper address bits must be zero to hit
    assign regIdx = paddr[6:2];
    assign wrEn = psel && penable && pwrite && isMapped(regIdx) &&
                  (paddr[31:7] == 25'h0000000) && (paddr[1:0] == 2'b00);

    // Zero wait states: read data is captured during setup
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(isMapped(regIdx) &&
                     (paddr[31:7] == 25'h0000000) && (paddr[1:0] == 2'b00));
    assign prdata = prdataQ;

    // Register writes; status is read-only and ignores writes
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            syncBeginQ <= rtp_pkg::RST_REG;
            syncStopQ <= rtp_pkg::RST_REG;
            modeDelayQ <= rtp_pkg::RST_REG;
            outputSelQ <= rtp_pkg::RST_REG;
            outCtrlQ <= rtp_pkg::RST_REG;
            vStartLoQ <= rtp_pkg::RST_REG;
            vStopLoQ <= rtp_pkg::RST_REG;
            vertCtrlQ <= rtp_pkg::RST_REG;
        end else if (wrEn) begin
            unique case (regIdx)
                rtp_pkg::IDX_SYNC_BEGIN: syncBeginQ <= pwdata[7:0];
                rtp_pkg::IDX_SYNC_STOP: syncStopQ <= pwdata[7:0];
                rtp_pkg::IDX_MODE_DELAY: modeDelayQ <= pwdata[7:0];
                rtp_pkg::IDX_OUTPUT_SEL: outputSelQ <= pwdata[7:0];
                rtp_pkg::IDX_OUT_CTRL: outCtrlQ <= pwdata[7:0];
                rtp_pkg::IDX_VSTART_LO: vStartLoQ <= pwdata[7:0];
                rtp_pkg::IDX_VSTOP_LO: vStopLoQ <= pwdata[7:0];
                rtp_pkg::IDX_VERT_CTRL: vertCtrlQ <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Read capture in the setup cycle; unmapped reads return zero
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            prdataQ <= 32'h00000000;
        end else if (psel && !penable) begin
            prdataQ <= 32'h00000000;
            if (!pwrite && paddr[31:7] == 25'h0000000 &&
                paddr[1:0] == 2'b00) begin
                unique case (regIdx)
                    rtp_pkg::IDX_SYNC_BEGIN: prdataQ[7:0] <= syncBeginQ;
                    rtp_pkg::IDX_SYNC_STOP: prdataQ[7:0] <= syncStopQ;
                    rtp_pkg::IDX_MODE_DELAY: prdataQ[7:0] <= modeDelayQ;
                    rtp_pkg::IDX_OUTPUT_SEL: prdataQ[7:0] <= outputSelQ;
                    rtp_pkg::IDX_OUT_CTRL: prdataQ[7:0] <= outCtrlQ;
                    rtp_pkg::IDX_VSTART_LO: prdataQ[7:0] <= vStartLoQ;
                    rtp_pkg::IDX_VSTOP_LO: prdataQ[7:0] <= vStopLoQ;
                    rtp_pkg::IDX_VERT_CTRL: prdataQ[7:0] <= vertCtrlQ;
                    rtp_pkg::IDX_STATUS: prdataQ[7:0] <= {fieldIdentQ,
                        tim.verticalWindowGate, tim.horizSyncPulse,
                        horizontalLockFlag, vLock, colourDetect,
                        oeNQ, pinQ};
                    default: ;
                endcase
            end
        end
    end

    // Configuration handed to the timing generators
    assign tim.pixelCount = pixelCount;
    assign tim.lineCount = lineCount;
    assign tim.syncBeginPos = syncBeginQ;
    assign tim.syncStopPos = syncStopQ;
    assign tim.horizFineDelay = modeDelayQ[rtp_pkg::POS_FINE_DELAY +: 2];
    assign tim.vertStartLine = {vertCtrlQ[rtp_pkg::POS_VSTART_MSB], vStartLoQ};
    assign tim.vertStopLine = {vertCtrlQ[rtp_pkg::POS_VSTOP_MSB], vStopLoQ};
    assign tim.vertGateAdjust = vertCtrlQ[rtp_pkg::POS_GATE_ADJUST];

    rtp_hsync_gen uHsync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .tim(tim.hsGen)
    );

    rtp_vertical_window_gate_gen uVgate (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .tim(tim.vgGen)
    );

    // 13.5 MHz qualifier
    // Phase accumulator: 100 MHz has no integer ratio, so edges jitter
    // by one clock while the average rate is exact
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            phaseQ <= rtp_pkg::RST_PHASE;
            pixelQualQ <= 1'b0;
        end else if (phaseQ + rtp_pkg::PHASE_STEP >= rtp_pkg::PHASE_WRAP) begin
            phaseQ <= 17'(phaseQ + rtp_pkg::PHASE_STEP - rtp_pkg::PHASE_WRAP);
            pixelQualQ <= !pixelQualQ;
        end else begin
            phaseQ <= 17'(phaseQ + rtp_pkg::PHASE_STEP);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            halfQualQ <= 1'b0;
        end else if (pixelQualQ && !pinQualNext()) begin
            halfQualQ <= !halfQualQ;
        end
    end

    // Falling edge of the pixel qualifier happens in the wrapping cycle
    function automatic logic pinQualNext();
        pinQualNext = (phaseQ + rtp_pkg::PHASE_STEP >= rtp_pkg::PHASE_WRAP) ?
                      !pixelQualQ : pixelQualQ;
    endfunction

    // field ident changes at start line
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            fieldIdentQ <= 1'b0;
        end else if (lineCount == tim.vertStartLine) begin
            fieldIdentQ <= fieldParity;
        end
    end

    assign horizontalLockFlag = outCtrlQ[rtp_pkg::POS_LOCK_SPEED] ?
                                hLockFast : hLockStandard;
    assign realtimePin0Invert = modeDelayQ[rtp_pkg::POS_INVERT];
    assign srcSel = rtp_pkg::rtp_sel_t'(outputSelQ[3:0]);

    // source select decode
    // Reserved codes drive the invert bit level so the pin never floats by accident
    always_comb begin
        selRaw = 1'b0;
        oeND = 1'b0;
        unique case (outputSelQ[3:0])
            rtp_pkg::SEL_TRISTATE: oeND = 1'b1;
            rtp_pkg::SEL_LOW: selRaw = 1'b0;
            rtp_pkg::SEL_PIXEL_QUAL: selRaw = pixelQualQ;
            rtp_pkg::SEL_HALF_QUAL: selRaw = halfQualQ;
            rtp_pkg::SEL_HLOCK: selRaw = horizontalLockFlag;
            rtp_pkg::SEL_FULL_LOCK: selRaw = vLock && horizontalLockFlag;
            rtp_pkg::SEL_LOCK_COLOUR: selRaw = vLock && horizontalLockFlag &&
                                               colourDetect;
            rtp_pkg::SEL_LINE_REF: selRaw = activeLineRef;
            rtp_pkg::SEL_HSYNC: selRaw = tim.horizSyncPulse;
            rtp_pkg::SEL_GATED_REF: selRaw = activeLineRef &&
                                             tim.verticalWindowGate;
            rtp_pkg::SEL_VSYNC: selRaw = verticalSyncOut;
            rtp_pkg::SEL_VERTICAL_WINDOW_GATE: selRaw = tim.verticalWindowGate;
            rtp_pkg::SEL_ADC_LSB: selRaw = adcLsb;
            rtp_pkg::SEL_FIELD: selRaw = fieldIdentQ;
            default: selRaw = 1'b0;
        endcase
        pinD = selRaw ^ realtimePin0Invert;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pinQ <= 1'b0;
            oeNQ <= 1'b1;
        end else begin
            pinQ <= oeND ? 1'b0 : pinD;
            oeNQ <= oeND;
        end
    end
    assign realtimePin0Out = pinQ;
    assign realtimePin0OeN = oeNQ;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence seqLineRefRise;
        !activeLineRef ##1 activeLineRef;
    endsequence

    sequence seqLockGain;
        !(vLock && horizontalLockFlag) ##1 (vLock && horizontalLockFlag);
    endsequence

    a_tristate_float: assert property (
        (srcSel == rtp_pkg::SEL_TRISTATE) |=> realtimePin0OeN)
        else $error("pin not floating for code 0000");
    a_const_low: assert property (
        (srcSel == rtp_pkg::SEL_LOW) |=>
        (!realtimePin0OeN && realtimePin0Out == $past(realtimePin0Invert)))
        else $error("constant low code wrong");
    a_invert_polarity: assert property (
        (outputSelQ[3:0] != 4'h0) |=>
        (realtimePin0Out == ($past(selRaw) ^ $past(realtimePin0Invert))))
        else $error("polarity not applied");
    a_qual_toggle: assert property (
        (srcSel == rtp_pkg::SEL_PIXEL_QUAL) |-> ##[1:4] $changed(pixelQualQ))
        else $error("pixel qualifier not toggling");
    a_half_rate: assert property (
        $changed(halfQualQ) |-> $fell(pixelQualQ))
        else $error("half rate edge without qualifier");
    a_lock_speed: assert property (
        (srcSel == rtp_pkg::SEL_HLOCK && !realtimePin0Invert) |=>
        (realtimePin0Out == ($past(outCtrlQ[rtp_pkg::POS_LOCK_SPEED]) ?
         $past(hLockFast) : $past(hLockStandard))))
        else $error("lock flag from wrong detector");
    a_full_lock: assert property (
        seqLockGain ##0 (srcSel == rtp_pkg::SEL_FULL_LOCK &&
        !realtimePin0Invert) |=> realtimePin0Out)
        else $error("full lock not shown");
    a_lock_colour: assert property (
        (srcSel == rtp_pkg::SEL_LOCK_COLOUR && !realtimePin0Invert &&
         !colourDetect) |=> !realtimePin0Out)
        else $error("colour lock high without colour");
    a_line_ref_edge: assert property (
        seqLineRefRise ##0 (srcSel == rtp_pkg::SEL_LINE_REF &&
        !realtimePin0Invert) |=> $rose(realtimePin0Out))
        else $error("line reference edge lost");
    a_gated_ref: assert property (
        (srcSel == rtp_pkg::SEL_GATED_REF && !realtimePin0Invert &&
         !tim.verticalWindowGate) |=> !realtimePin0Out)
        else $error("gated reference outside gate");
    a_field_load: assert property (
        (lineCount == tim.vertStartLine) |=> (fieldIdentQ == $past(fieldParity)))
        else $error("field ident not loaded at start line");
endmodule

// ==== rtp_pin_sink.sv ====
// Downstream back-end model that samples real-time pin 0
`timescale 1ns/1ps
module rtp_pin_sink (
    input wire logic clk_sys,
    input wire logic pinOut,
    input wire logic pinOeN,
    output logic pinWire,
    output logic sampledLevel
);
    logic lastDriven = 1'b0;
    // Pin has no pull, so a released pin never keeps its last level
    always_comb begin
        pinWire = pinOeN ? ~lastDriven : pinOut;
    end
    // Back end samples the wire on the system clock
    always_ff @(posedge clk_sys) begin
        sampledLevel <= pinWire;
        if (!pinOeN) begin
            lastDriven <= pinOut;
        end
    end
endmodule

// ==== rt_pin0_output_select_test.sv ====
// Self-checking bench for the real-time pin 0 output selector
`timescale 1ns/1ps
module rt_pin0_output_select_test;
    logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [10:0] pixelCount;
    logic [8:0] lineCount;
    logic hLockStandard, hLockFast, vLock, colourDetect, activeLineRef;
    logic verticalSyncOut, adcLsb, fieldParity, er, inv;
    logic realtimePin0Out, realtimePin0OeN, pinWire;
    int err_count = 0;
    int comparisons = 0;
    int f0, h0, t0, f1, h1, t1;

    rtp_output_select dut_u (.clk_sys(clk_sys), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pixelCount(pixelCount),
        .lineCount(lineCount), .hLockStandard(hLockStandard),
        .hLockFast(hLockFast), .vLock(vLock),
        .colourDetect(colourDetect), .activeLineRef(activeLineRef),
        .verticalSyncOut(verticalSyncOut), .adcLsb(adcLsb),
        .fieldParity(fieldParity), .realtimePin0Out(realtimePin0Out),
        .realtimePin0OeN(realtimePin0OeN));
    rtp_pin_sink sink_u (.clk_sys(clk_sys), .pinOut(realtimePin0Out),
        .pinOeN(realtimePin0OeN), .pinWire(pinWire), .sampledLevel());

    // Free-running 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (err_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic xfer(input logic [4:0] idx, input logic w,
                        input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {25'h0000000, idx, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1) begin
            err_count++;
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Select a source, then check the registered pin two edges later
    task automatic pin(input logic [3:0] code, input logic exp);
        xfer(rtp_pkg::IDX_OUTPUT_SEL, 1'b1, {4'h0, code});
        repeat (2) @(posedge clk_sys);
        #1;
        chk(realtimePin0OeN, 32'h0);
        chk(realtimePin0Out, exp ^ inv);
    endtask

    // Step the counters and record how the pin wire behaves
    task automatic sweep(input int n, input int dv, input logic [8:0] b,
                         output int first, output int highs, output int tg);
        logic prev;
        first = -1;
        highs = 0;
        tg = 0;
        prev = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            pixelCount <= 11'(i);
            lineCount <= b + 9'(i / dv);
            #1;
            if (pinWire === 1'b1) begin
                highs++;
                if (first < 0) first = i;
            end
            if (i > 0 && pinWire !== prev) tg++;
            prev = pinWire;
        end
    endtask

    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {pixelCount, lineCount, hLockStandard, hLockFast, vLock} = '0;
        {colourDetect, activeLineRef, verticalSyncOut, adcLsb} = '0;
        {fieldParity, inv} = '0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        #1;
        chk(realtimePin0OeN, 32'h1);
        xfer(rtp_pkg::IDX_OUTPUT_SEL, 1'b0, 8'h00);
        chk(rd, 32'h0);
        xfer(rtp_pkg::IDX_OUTPUT_SEL, 1'b1, 8'hA4);
        xfer(rtp_pkg::IDX_OUTPUT_SEL, 1'b0, 8'h00);
        chk(rd, 32'hA4);
        xfer(5'h01, 1'b1, 8'hFF);
        chk(er, 32'h1);
        xfer(5'h01, 1'b0, 8'h00);
        chk({er, rd[30:0]}, 32'h80000000);
        // reserved codes never selected; lock inputs only change between pin checks
        for (int k = 0; k < 2; k++) begin
            inv = 1'(k);
            xfer(rtp_pkg::IDX_MODE_DELAY, 1'b1, {4'h0, inv, 3'h0});
            pin(rtp_pkg::SEL_LOW, 1'b0);
            {hLockStandard, vLock, colourDetect} <= 3'b110;
            xfer(rtp_pkg::IDX_OUT_CTRL, 1'b1, 8'h08);
            pin(rtp_pkg::SEL_HLOCK, 1'b0);
            xfer(rtp_pkg::IDX_OUT_CTRL, 1'b1, 8'h00);
            pin(rtp_pkg::SEL_HLOCK, 1'b1);
            pin(rtp_pkg::SEL_FULL_LOCK, 1'b1);
            pin(rtp_pkg::SEL_LOCK_COLOUR, 1'b0);
            colourDetect <= 1'b1;
            pin(rtp_pkg::SEL_LOCK_COLOUR, 1'b1);
            vLock <= 1'b0;
            pin(rtp_pkg::SEL_FULL_LOCK, 1'b0);
            activeLineRef <= 1'b1;
            pin(rtp_pkg::SEL_LINE_REF, 1'b1);
            activeLineRef <= 1'b0;
            pin(rtp_pkg::SEL_LINE_REF, 1'b0);
            verticalSyncOut <= ~inv;
            pin(rtp_pkg::SEL_VSYNC, ~inv);
            adcLsb <= ~inv;
            pin(rtp_pkg::SEL_ADC_LSB, ~inv);
        end
        inv = 1'b0;
        xfer(rtp_pkg::IDX_MODE_DELAY, 1'b1, 8'h00);
        // Toggling sources: only the enable is checked before the sweep
        xfer(rtp_pkg::IDX_OUTPUT_SEL, 1'b1, {4'h0, rtp_pkg::SEL_PIXEL_QUAL});
        repeat (2) @(posedge clk_sys);
        #1;
        chk(realtimePin0OeN, 32'h0);
        sweep(1000, 1000, 9'h000, f0, h0, t0);
        chk(t0 >= 268 && t0 <= 272, 32'h1);
        xfer(rtp_pkg::IDX_OUTPUT_SEL, 1'b1, {4'h0, rtp_pkg::SEL_HALF_QUAL});
        repeat (2) @(posedge clk_sys);
        #1;
        chk(realtimePin0OeN, 32'h0);
        sweep(1000, 1000, 9'h000, f0, h0, t0);
        chk(t0 >= 133 && t0 <= 137, 32'h1);
        // Sync 2..4 in eight-clock steps: 16 clocks wide
        xfer(rtp_pkg::IDX_SYNC_BEGIN, 1'b1, 8'h02);
        xfer(rtp_pkg::IDX_SYNC_STOP, 1'b1, 8'h04);
        pin(rtp_pkg::SEL_HSYNC, 1'b0);
        sweep(64, 1000, 9'h000, f0, h0, t0);
        xfer(rtp_pkg::IDX_MODE_DELAY, 1'b1, 8'h30);
        sweep(64, 1000, 9'h000, f1, h1, t1);
        chk(h0, 32'd16);
        chk(h1, 32'd16);
        chk(f1 - f0, 32'd6);
        // Gate lines 0x105 to 0x107, four clocks per line
        // Park on the stop line so a gate set by the reset values clears
        lineCount <= 9'h108;
        xfer(rtp_pkg::IDX_MODE_DELAY, 1'b1, 8'h00);
        xfer(rtp_pkg::IDX_VSTART_LO, 1'b1, 8'h05);
        xfer(rtp_pkg::IDX_VSTOP_LO, 1'b1, 8'h08);
        xfer(rtp_pkg::IDX_VERT_CTRL, 1'b1, 8'h03);
        pin(rtp_pkg::SEL_VERTICAL_WINDOW_GATE, 1'b0);
        sweep(64, 4, 9'h100, f0, h0, t0);
        xfer(rtp_pkg::IDX_VERT_CTRL, 1'b1, 8'h07);
        sweep(64, 4, 9'h100, f1, h1, t1);
        chk(h0, 32'd12);
        chk(f1 - f0, 32'd4);
        xfer(rtp_pkg::IDX_VERT_CTRL, 1'b1, 8'h03);
        activeLineRef <= 1'b1;
        xfer(rtp_pkg::IDX_OUTPUT_SEL, 1'b1, 8'h0A);
        sweep(64, 4, 9'h100, f1, h1, t1);
        chk(h1, 32'd12);
        activeLineRef <= 1'b0;
        sweep(64, 4, 9'h100, f1, h1, t1);
        chk(h1, 32'd0);
        // Field ident takes the new parity only from the start line on
        fieldParity <= 1'b1;
        pin(rtp_pkg::SEL_FIELD, 1'b0);
        sweep(64, 4, 9'h100, f1, h1, t1);
        chk(f1 >= 20 && h1 > 36, 32'h1);
        end_sim();
    end
endmodule
